// ### common/mcpp_pkg.sv
package mcpp_pkg;

  // Bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int BUF_DEPTH = 32;

  // Register map
  localparam logic [7:0] CTRL_ADDR = 8'h00;
  localparam logic [1:0] BUF_A_TAG = 2'h1;
  localparam logic [1:0] BUF_B_TAG = 2'h2;
  localparam int BUF_TAG_LSB = 6;

  // Control word field positions
  localparam int BIT_SELECT = 10;
  localparam int BIT_ACK = 8;
  localparam int UNUSED_MSB = 7;
  localparam int UNUSED_LSB = 4;
  localparam int BIT_STOP = 3;
  localparam int BIT_ENABLE = 2;

  // Reset values
  localparam logic RST_ACK = 1'b0;
  localparam logic RST_STOP = 1'b0;
  localparam logic RST_ENABLE = 1'b0;
  localparam logic RST_SELECT = 1'b0;
  localparam logic [15:0] RST_WORD = 16'h0000;

  // Bank codes
  localparam logic BANK_A = 1'b0;
  localparam logic BANK_B = 1'b1;

  typedef enum logic [1:0] {
    MCPP_HS_OFF = 2'b00,
    MCPP_HS_ACTIVE = 2'b01,
    MCPP_HS_SUSPENDED = 2'b10
  } mcpp_hs_e;

  // Message events from the terminal core
  typedef struct packed {
    logic start;
    logic word_valid;
    logic [DATA_W-1:0] word;
    logic done;
    logic ok;
  } mcpp_msg_s;

  // Host-written control bits
  typedef struct packed {
    logic enable;
    logic stop;
  } mcpp_ctl_s;

endpackage

// ### verification/mcpp_msg_model.sv
`timescale 1ns/1ps
module mcpp_msg_model (
  input wire logic clock,
  input wire logic go,
  input wire logic [5:0] nwords,
  input wire logic [15:0] base,
  input wire logic good,
  output mcpp_pkg::mcpp_msg_s msg,
  output logic idle
);
  // Terminal core side: start, words, then done with status
  initial begin
    int k;
    msg = '0;
    idle = 1'b1;
    forever begin
      @(posedge clock);
      if (go) begin
        idle <= 1'b0;
        msg.start <= 1'b1;
        for (k = 0; k < nwords; k++) begin
          @(posedge clock);
          msg.start <= 1'b0;
          msg.word_valid <= 1'b1;
          msg.word <= base + 16'(k);
        end
        @(posedge clock);
        msg.start <= 1'b0;
        msg.word_valid <= 1'b0;
        msg.word <= ~msg.word;
        msg.done <= 1'b1;
        msg.ok <= good;
        @(posedge clock);
        msg.done <= 1'b0;
        msg.ok <= 1'b0;
        idle <= 1'b1;
      end
    end
  end
endmodule // mcpp_msg_model

// ### verification/mcpp_top_test.sv
`timescale 1ns/1ps
module mcpp_top_test;
  logic clock;
  logic rst;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata;
  logic reg_we;
  logic reg_re;
  logic [15:0] reg_rdata;
  mcpp_pkg::mcpp_msg_s msg;
  logic pingpong_ack;
  logic buffer_select_flag;
  logic msg_busy;
  logic msg_bank;
  logic go;
  logic [5:0] nwords;
  logic [15:0] base;
  logic good;
  logic idle;
  int failures;
  int comparisons;

  mcpp_top u_dut (.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
    .reg_re(reg_re), .reg_rdata(reg_rdata), .msg(msg), .pingpong_ack(pingpong_ack),
    .buffer_select_flag(buffer_select_flag), .msg_busy(msg_busy), .msg_bank(msg_bank));
  mcpp_msg_model u_msg (.clock(clock), .go(go), .nwords(nwords), .base(base), .good(good), .msg(msg), .idle(idle));

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  task check(input string name, input logic [15:0] seen, input logic [15:0] expd);
    comparisons++;
    if (seen !== expd) begin
      failures++;
      $display("wrong value %s expected %h seen %h", name, expd, seen);
    end
  endtask

  task end_of_test;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_we <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_we <= 1'b0;
  endtask

  task rd(input logic [7:0] a, input logic [15:0] e, input string name);
    @(posedge clock);
    reg_re <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_re <= 1'b0;
    #1;
    check(name, reg_rdata, e);
  endtask

  task ack_is(input logic e);
    repeat (2) @(posedge clock);
    #1;
    check("ack", 16'(pingpong_ack), 16'(e));
  endtask

  task send(input logic [5:0] n, input logic [15:0] b, input logic g, input logic bank, input logic sel);
    int i;
    @(posedge clock);
    go <= 1'b1;
    nwords <= n;
    base <= b;
    good <= g;
    @(posedge clock);
    go <= 1'b0;
    for (i = 0; i < 20 && msg_busy !== 1'b1; i++) begin
      @(posedge clock);
      #1;
    end
    check("busy", 16'(msg_busy), 16'h0001);
    check("bank", 16'(msg_bank), 16'(bank));
    for (i = 0; i < 80 && idle !== 1'b1; i++) begin
      @(posedge clock);
      #1;
    end
    @(posedge clock);
    #1;
    check("busy", 16'(msg_busy), 16'h0000);
    check("select", 16'(buffer_select_flag), 16'(sel));
  endtask

  task test_reset;
    rd(8'h00, 16'h0000, "ctrl");
    wr(8'h00, 16'h05f0);
    rd(8'h00, 16'h0000, "ctrl");
    ack_is(1'b0);
    rd(8'h10, 16'h0000, "unmapped");
    $display("done test_reset");
  endtask

  task test_enable;
    wr(8'h00, 16'h0004);
    ack_is(1'b1);
    rd(8'h00, 16'h0104, "ctrl");
    $display("done test_enable");
  endtask

  task test_double;
    send(6'h03, 16'hc000, 1'b1, mcpp_pkg::BANK_A, 1'b1);
    send(6'h02, 16'hd000, 1'b0, mcpp_pkg::BANK_B, 1'b1);
    wr(8'h00, 16'h000c);
    ack_is(1'b0);
    rd(8'h41, 16'hc001, "buf_a");
    rd(8'h80, 16'hd000, "buf_b");
    wr(8'h00, 16'h0004);
    ack_is(1'b1);
    $display("done test_double");
  endtask

  task test_suspend;
    wr(8'h00, 16'h000c);
    ack_is(1'b0);
    rd(8'h00, 16'h040c, "ctrl");
    send(6'h03, 16'h1000, 1'b1, mcpp_pkg::BANK_B, 1'b1);
    send(6'h02, 16'h2000, 1'b1, mcpp_pkg::BANK_B, 1'b1);
    rd(8'h80, 16'h2000, "buf_b");
    rd(8'h82, 16'h1002, "buf_b");
    wr(8'h81, 16'h3333);
    rd(8'h81, 16'h3333, "buf_b");
    wr(8'h00, 16'h0004);
    ack_is(1'b1);
    $display("done test_suspend");
  endtask

  task test_single;
    wr(8'h00, 16'h0000);
    ack_is(1'b0);
    send(6'h01, 16'h4000, 1'b1, mcpp_pkg::BANK_A, 1'b1);
    rd(8'h40, 16'h4000, "buf_a");
    send(6'h21, 16'h5000, 1'b1, mcpp_pkg::BANK_A, 1'b1);
    rd(8'h5f, 16'h501f, "buf_a");
    rd(8'h40, 16'h5000, "buf_a");
    $display("done test_single");
  endtask

  task test_mid_reset;
    wr(8'h00, 16'h0004);
    ack_is(1'b1);
    @(posedge clock);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    rd(8'h00, 16'h0000, "ctrl");
    ack_is(1'b0);
    $display("done test_mid_reset");
  endtask

  initial begin
    #100000;
    failures++;
    end_of_test;
  end

  initial begin
    rst = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    reg_we = 1'b0;
    reg_re = 1'b0;
    go = 1'b0;
    nwords = 6'h00;
    base = 16'h0000;
    good = 1'b0;
    failures = 0;
    comparisons = 0;
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    test_reset;
    test_enable;
    test_double;
    test_suspend;
    test_single;
    test_mid_reset;
    end_of_test;
  end
endmodule // mcpp_top_test

// ### verilog/mcpp_buffer.sv
`timescale 1ns/1ps
module mcpp_buffer #(
  parameter int DEPTH = mcpp_pkg::BUF_DEPTH,
  parameter int DATA_W = mcpp_pkg::DATA_W,
  parameter int IDX_W = $clog2(DEPTH)
) (
  input wire logic clock,
  input wire logic dev_we,
  input wire logic dev_bank,
  input wire logic [IDX_W-1:0] dev_index,
  input wire logic [DATA_W-1:0] dev_data,
  input wire logic host_we,
  input wire logic host_bank,
  input wire logic [IDX_W-1:0] host_index,
  input wire logic [DATA_W-1:0] host_wdata,
  output logic [DATA_W-1:0] host_rdata
);

  logic [DATA_W-1:0] mem [2*DEPTH];

  // Device write wins a same-word collision
  always_ff @(posedge clock) begin
    if (dev_we) begin
      mem[{dev_bank, dev_index}] <= dev_data; // R8
    end
    if (host_we && !(dev_we && dev_bank == host_bank && dev_index == host_index)) begin
      mem[{host_bank, host_index}] <= host_wdata;
    end
  end

  assign host_rdata = mem[{host_bank, host_index}];

endmodule // mcpp_buffer

// ### verilog/mcpp_handshake.sv
`timescale 1ns/1ps
module mcpp_handshake (
  input wire logic clock,
  input wire logic rst,
  input wire logic enable,
  input wire logic stop,
  input wire logic busy,
  output logic ack,
  output mcpp_pkg::mcpp_hs_e state
);

  typedef struct packed {
    mcpp_pkg::mcpp_hs_e hs;
  } mcpp_hs_state_s;

  mcpp_hs_state_s s_q;
  mcpp_hs_state_s s_d;

  always_comb begin
    s_d = s_q;
    case (s_q.hs)
      mcpp_pkg::MCPP_HS_OFF: begin
        if (enable && !busy) begin
          s_d.hs = stop ? mcpp_pkg::MCPP_HS_SUSPENDED : mcpp_pkg::MCPP_HS_ACTIVE; // R2
        end
      end
      mcpp_pkg::MCPP_HS_ACTIVE: begin
        if (!enable) begin
          s_d.hs = mcpp_pkg::MCPP_HS_OFF; // R1
        end else if (stop && !busy) begin
          s_d.hs = mcpp_pkg::MCPP_HS_SUSPENDED; // R4
        end
      end
      mcpp_pkg::MCPP_HS_SUSPENDED: begin
        if (!enable) begin
          s_d.hs = mcpp_pkg::MCPP_HS_OFF; // R1
        end else if (!stop && !busy) begin
          s_d.hs = mcpp_pkg::MCPP_HS_ACTIVE; // R7
        end
      end
      default: begin
        s_d.hs = mcpp_pkg::MCPP_HS_OFF;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s_q.hs <= mcpp_pkg::MCPP_HS_OFF; // R12
    end else begin
      s_q <= s_d;
    end
  end

  assign ack = (s_q.hs == mcpp_pkg::MCPP_HS_ACTIVE); // R2
  assign state = s_q.hs;

endmodule // mcpp_handshake

// ### verilog/mcpp_top.sv
// Behaviour
// (R1) Ack flag read only, valid when enabled
// (R2) Set ack when double buffering active
// (R3) Host sets stop before unloading buffer
// (R4) Stop request clears ack
// (R5) Host touches buffer only while ack low
// (R6) Host clears stop after servicing buffer
// (R7) Cleared stop sets ack again
// (R8) Suspended: store into selected buffer, overwrite
// (R9) Suspended: buffer select stays unchanged
// (R10) Enable one: double, zero: single buffering
// (R11) Select picks A/B, toggles on good completion
// (R12) Reset clears ack, stop; bits 7-4 ignored
//
// The plain strobed port and the address map were decided locally.
`timescale 1ns/1ps
module mcpp_top #(
  parameter int DEPTH = mcpp_pkg::BUF_DEPTH,
  parameter int IDX_W = $clog2(DEPTH)
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [mcpp_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [mcpp_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [mcpp_pkg::DATA_W-1:0] reg_rdata,
  input wire mcpp_pkg::mcpp_msg_s msg,
  output logic pingpong_ack,
  output logic buffer_select_flag,
  output logic msg_busy,
  output logic msg_bank
);

  typedef struct packed {
    logic [mcpp_pkg::DATA_W-1:0] rdata;
    mcpp_pkg::mcpp_ctl_s ctl;
    logic select;
    logic busy;
    logic pp_msg;
    logic bank;
    logic full;
    logic [IDX_W-1:0] index;
  } mcpp_top_state_s;

  mcpp_top_state_s s_q;
  mcpp_top_state_s s_d;

  logic ack;
  logic ctrl_hit;
  logic buf_a_hit;
  logic buf_b_hit;
  logic buf_hit;
  logic host_bank;
  logic host_buf_we;
  logic dev_we;
  logic [mcpp_pkg::DATA_W-1:0] buf_rdata;
  logic [mcpp_pkg::DATA_W-1:0] ctrl_word;
  logic [1:0] addr_tag;
  mcpp_pkg::mcpp_hs_e hs_state;

  // Address decode
  assign addr_tag = reg_addr[mcpp_pkg::BUF_TAG_LSB +: 2];
  assign ctrl_hit = (reg_addr == mcpp_pkg::CTRL_ADDR);
  assign buf_a_hit = (addr_tag == mcpp_pkg::BUF_A_TAG);
  assign buf_b_hit = (addr_tag == mcpp_pkg::BUF_B_TAG);
  assign buf_hit = (buf_a_hit || buf_b_hit) && (reg_addr[mcpp_pkg::BUF_TAG_LSB-1:0] < 6'(DEPTH));
  assign host_bank = buf_b_hit ? mcpp_pkg::BANK_B : mcpp_pkg::BANK_A;
  assign host_buf_we = reg_we && buf_hit;

  // Device writes words of the running message
  assign dev_we = s_q.busy && msg.word_valid && !s_q.full; // R8

  // Control word as read by the host
  always_comb begin
    ctrl_word = mcpp_pkg::RST_WORD; // R12
    ctrl_word[mcpp_pkg::BIT_SELECT] = s_q.select;
    ctrl_word[mcpp_pkg::BIT_ACK] = ack; // R1
    ctrl_word[mcpp_pkg::BIT_STOP] = s_q.ctl.stop;
    ctrl_word[mcpp_pkg::BIT_ENABLE] = s_q.ctl.enable;
  end

  always_comb begin
    s_d = s_q;
    s_d.rdata = mcpp_pkg::RST_WORD;
    if (reg_re) begin
      if (ctrl_hit) begin
        s_d.rdata = ctrl_word;
      end else if (buf_hit) begin
        s_d.rdata = buf_rdata;
      end
    end
    // Only stop and enable are writable; ack, select, 7-4 ignored
    if (reg_we && ctrl_hit) begin
      s_d.ctl.stop = reg_wdata[mcpp_pkg::BIT_STOP]; // R1
      s_d.ctl.enable = reg_wdata[mcpp_pkg::BIT_ENABLE]; // R10
    end
    if (!s_q.busy) begin
      if (msg.start) begin
        s_d.busy = 1'b1;
        s_d.pp_msg = s_q.ctl.enable && ack; // R10
        s_d.bank = s_q.ctl.enable ? s_q.select : mcpp_pkg::BANK_A; // R11
        s_d.index = '0;
        s_d.full = 1'b0;
      end
    end else begin
      if (dev_we) begin
        s_d.index = IDX_W'(s_q.index + 1'b1);
        s_d.full = (s_q.index == IDX_W'(DEPTH - 1));
      end
      if (msg.done) begin
        s_d.busy = 1'b0;
        if (s_q.pp_msg && msg.ok) begin // R9
          s_d.select = ~s_q.select; // R11
        end
        // Suspended or failed messages keep the select flag
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s_q.rdata <= mcpp_pkg::RST_WORD;
      s_q.ctl.enable <= mcpp_pkg::RST_ENABLE;
      s_q.ctl.stop <= mcpp_pkg::RST_STOP; // R12
      s_q.select <= mcpp_pkg::RST_SELECT;
      s_q.busy <= 1'b0;
      s_q.pp_msg <= 1'b0;
      s_q.bank <= mcpp_pkg::BANK_A;
      s_q.full <= 1'b0;
      s_q.index <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  mcpp_handshake u_handshake (
    .clock(clock),
    .rst(rst),
    .enable(s_q.ctl.enable),
    .stop(s_q.ctl.stop),
    .busy(s_q.busy),
    .ack(ack),
    .state(hs_state)
  );

  mcpp_buffer #(
    .DEPTH(DEPTH),
    .DATA_W(mcpp_pkg::DATA_W),
    .IDX_W(IDX_W)
  ) u_buffer (
    .clock(clock),
    .dev_we(dev_we),
    .dev_bank(s_q.bank),
    .dev_index(s_q.index),
    .dev_data(msg.word),
    .host_we(host_buf_we),
    .host_bank(host_bank),
    .host_index(reg_addr[IDX_W-1:0]),
    .host_wdata(reg_wdata),
    .host_rdata(buf_rdata)
  );

  assign reg_rdata = s_q.rdata;
  assign pingpong_ack = ack;
  assign buffer_select_flag = s_q.select;
  assign msg_busy = s_q.busy;
  assign msg_bank = s_q.bank;

  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence s_suspend_req;
    ack && s_q.ctl.stop && s_q.ctl.enable && !s_q.busy;
  endsequence

  sequence s_resume_req;
    s_q.ctl.enable && !s_q.ctl.stop && !ack && !s_q.busy;
  endsequence

  sequence s_ctrl_write;
    reg_we && ctrl_hit;
  endsequence

  sequence s_ctrl_read;
    reg_re && ctrl_hit;
  endsequence

  sequence s_suspended_start;
    msg.start && !s_q.busy && s_q.ctl.enable && !ack;
  endsequence

  sequence s_double_start;
    msg.start && !s_q.busy && s_q.ctl.enable && ack;
  endsequence

  sequence s_msg_start;
    msg.start && !s_q.busy;
  endsequence

  sequence s_msg_end;
    s_q.busy && msg.done;
  endsequence

  sequence s_dev_word;
    s_q.busy && msg.word_valid && !s_q.full;
  endsequence

  sequence s_last_word;
    s_q.busy && msg.word_valid && !s_q.full && s_q.index == IDX_W'(DEPTH - 1);
  endsequence

  sequence s_buf_idle;
    !s_q.busy && !msg.start;
  endsequence

  a_ack_needs_enable: assert property (!s_q.ctl.enable |=> !ack) // R1
    else $error("ack high without enable");

  a_ack_read_back: assert property (s_ctrl_read |=> reg_rdata[mcpp_pkg::BIT_ACK] == $past(ack)) // R1
    else $error("ack read back wrong");

  a_ack_sets: assert property (s_q.ctl.enable && !s_q.ctl.stop && !s_q.busy |=> ack) // R2
    else $error("ack not set while active");

  a_suspend_ack: assert property (s_suspend_req |=> !ack ##1 (!ack || !$past(s_q.ctl.stop))) // R4
    else $error("stop request not acknowledged");

  a_resume_ack: assert property ($fell(s_q.ctl.stop) ##0 s_resume_req |=> ack) // R7
    else $error("resume not acknowledged");

  a_suspended_bank: assert property (s_suspended_start |=> // R8
    s_q.busy && !s_q.pp_msg && s_q.bank == $past(s_q.select))
    else $error("suspended message uses wrong buffer");

  a_select_hold: assert property (s_q.busy && msg.done && !s_q.pp_msg |=> $stable(s_q.select)) // R9
    else $error("select moved while suspended");

  a_select_toggle: assert property (s_msg_end ##0 s_q.pp_msg && msg.ok |=> s_q.select != $past(s_q.select)) // R11
    else $error("select not toggled after good message");

  a_single_bank_a: assert property (s_msg_start ##0 !s_q.ctl.enable |=> s_q.bank == mcpp_pkg::BANK_A) // R10
    else $error("single buffering left bank A");

  a_unused_zero: assert property (s_ctrl_write ##[1:3] s_ctrl_read |=> // R12
    reg_rdata[mcpp_pkg::UNUSED_MSB:mcpp_pkg::UNUSED_LSB] == 4'h0)
    else $error("unused bits not zero");

  a_reset_clear: assert property (disable iff (1'b0) rst |=> !ack && !s_q.ctl.stop) // R12
    else $error("reset left ack or stop set");

  a_state_legal: assert property (hs_state inside {mcpp_pkg::MCPP_HS_OFF, mcpp_pkg::MCPP_HS_ACTIVE, // R2
    mcpp_pkg::MCPP_HS_SUSPENDED})
    else $error("handshake state illegal");

  a_enable_off_state: assert property (!s_q.ctl.enable |=> hs_state == mcpp_pkg::MCPP_HS_OFF) // R1
    else $error("handshake not off without enable");

  a_stop_clears_ack: assert property (s_q.ctl.enable && s_q.ctl.stop && !s_q.busy |=> !ack) // R4
    else $error("ack high with stop request");

  a_busy_no_suspend: assert property (s_q.busy && ack && s_q.ctl.enable |=> ack) // R4
    else $error("ack dropped during message");

  a_busy_no_resume: assert property (s_q.busy && !ack |=> !ack) // R7
    else $error("ack rose during message");

  a_start_busy: assert property (s_msg_start |=> s_q.busy) // R8
    else $error("message start not taken");

  a_start_index_zero: assert property (s_msg_start |=> s_q.index == '0 && !s_q.full) // R8
    else $error("message index not cleared");

  a_double_bank: assert property (s_double_start |=> s_q.pp_msg && s_q.bank == $past(s_q.select)) // R11
    else $error("double buffered message uses wrong buffer");

  a_msg_end_idle: assert property (s_msg_end |=> !s_q.busy) // R8
    else $error("message end not taken");

  a_word_index: assert property (s_dev_word |=> s_q.index == IDX_W'($past(s_q.index) + 1'b1)) // R8
    else $error("word index not advanced");

  a_index_idle_hold: assert property (s_buf_idle |=> $stable(s_q.index)) // R8
    else $error("word index moved while idle");

  a_full_after_depth: assert property (s_last_word |=> s_q.full) // R8
    else $error("buffer not full after last word");

  a_full_holds: assert property (s_q.full && s_q.busy |=> s_q.full) // R8
    else $error("full flag dropped during message");

  a_busy_holds_bank: assert property (s_q.busy |=> $stable(s_q.bank)) // R8
    else $error("bank changed during message");

  a_select_idle_stable: assert property (!s_q.busy |=> $stable(s_q.select)) // R9
    else $error("select moved while idle");

  a_fail_keeps_select: assert property (s_msg_end ##0 !msg.ok |=> $stable(s_q.select)) // R11
    else $error("select moved after failed message");

  a_stop_write: assert property (s_ctrl_write |=> s_q.ctl.stop == $past(reg_wdata[mcpp_pkg::BIT_STOP])) // R1
    else $error("stop bit not written");

  a_enable_write: assert property (s_ctrl_write |=> s_q.ctl.enable == $past(reg_wdata[mcpp_pkg::BIT_ENABLE])) // R10
    else $error("enable bit not written");

  a_ctl_hold: assert property (!(reg_we && ctrl_hit) |=> $stable(s_q.ctl)) // R10
    else $error("control bits moved without write");

  a_rdata_idle_zero: assert property (!reg_re |=> reg_rdata == mcpp_pkg::RST_WORD) // R1
    else $error("read data not zero without read");

  a_select_read_back: assert property (s_ctrl_read |=> reg_rdata[mcpp_pkg::BIT_SELECT] == $past(s_q.select)) // R11
    else $error("select read back wrong");

  a_stop_read_back: assert property (s_ctrl_read |=> reg_rdata[mcpp_pkg::BIT_STOP] == $past(s_q.ctl.stop)) // R1
    else $error("stop read back wrong");

  a_enable_read_back: assert property (s_ctrl_read |=> reg_rdata[mcpp_pkg::BIT_ENABLE] == $past(s_q.ctl.enable)) // R10
    else $error("enable read back wrong");

endmodule // mcpp_top
